// File: fpu_exc_pkg.sv
`default_nettype none
package fpu_exc_pkg;
   // ***************************************
   // Exception classes
   // ***************************************
   localparam int NCLS     = 6;
   localparam int IDX_INV  = 0;
   localparam int IDX_ZERO = 1;
   localparam int IDX_DEN  = 2;
   localparam int IDX_OVF  = 3;
   localparam int IDX_UNF  = 4;
   localparam int IDX_PREC = 5;

   // ***************************************
   // Register map
   // ***************************************
   localparam logic [11:0] OFS_STATUS  = 12'h000;
   localparam logic [11:0] OFS_CONTROL = 12'h004;
   localparam logic [11:0] OFS_COMMAND = 12'h008;
   localparam logic [11:0] OFS_SYSCTL  = 12'h00c;
   localparam int          SW_FLAG_LSB = 0;
   localparam int          SW_SF       = 6;
   localparam int          SW_ES       = 7;
   localparam int          SW_C1       = 9;
   localparam int          SW_TOP_LSB  = 11;
   localparam int          TOP_W       = 3;
   localparam int          CMD_CLEX    = 0;
   localparam int          CMD_INIT    = 1;
   localparam int          SYS_NE      = 0;
   localparam logic [5:0]  MASK_RST    = 6'h3f;
   localparam logic [5:0]  FLAG_RST    = 6'h00;
   localparam logic [2:0]  TOP_RST     = 3'h0;
   localparam logic [7:0]  VEC_NUMERIC = 8'h10;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // ***************************************
   // Extended real layout
   // ***************************************
   localparam int          EXP_W   = 15;
   localparam int          SIG_W   = 64;
   localparam int          FP_W    = 80;
   localparam int          INT_BIT = 63;
   localparam logic [14:0] EXP_MAX = 15'h7fff;
   localparam logic [14:0] EXP_MIN = 15'h0000;

   // ***************************************
   // Types
   // ***************************************
   typedef enum logic [1:0] {
      K_CONTROL = 2'h0,
      K_ARITH   = 2'h1,
      K_WAIT    = 2'h2
   } insn_kind_e;

   typedef enum logic [1:0] {
      ST_RUN    = 2'b00,
      ST_FREEZE = 2'b01
   } gate_state_e;

   typedef struct packed {
      logic       valid;
      insn_kind_e kind;
   } insn_req_s;

   typedef struct packed {
      logic valid;
      logic inv_arith;
      logic stack;
      logic push;
      logic zero_div;
      logic denorm;
      logic overflow;
      logic underflow;
      logic precision;
   } exc_report_s;

   typedef struct packed {
      logic fixup;
      logic qnan_write;
      logic keep_operands;
   } exc_resp_s;
endpackage
`default_nettype wire

// File: fpu_operand_classifier.sv
`timescale 1ns/1ps
`default_nettype none
module fpu_operand_classifier (
   // Operand
   input  wire logic [fpu_exc_pkg::FP_W-1:0] operand,
   // Class
   output logic                              unsupported,
   output logic                              denormal
);
   logic [fpu_exc_pkg::EXP_W-1:0] exp_f;
   logic                          int_b;
   logic                          frac_nz;

   always_comb begin
      exp_f   = operand[fpu_exc_pkg::FP_W-2 -: fpu_exc_pkg::EXP_W];
      int_b   = operand[fpu_exc_pkg::INT_BIT];
      frac_nz = |operand[fpu_exc_pkg::INT_BIT-1:0];
      // Pseudo-NaN, pseudoinfinity, unnormal, pseudodenormal
      unsupported = ((exp_f == fpu_exc_pkg::EXP_MAX) && !int_b) ||
                    ((exp_f != fpu_exc_pkg::EXP_MAX) && (exp_f != fpu_exc_pkg::EXP_MIN)
                     && !int_b) ||
                    ((exp_f == fpu_exc_pkg::EXP_MIN) && int_b);
      denormal    = (exp_f == fpu_exc_pkg::EXP_MIN) && !int_b && frac_nz;
   end
endmodule
`default_nettype wire

// File: fpu_numeric_exception_unit.sv
// Overview of operation
// - Six exception classes, each with a sticky flag and a mask bit.
// - Masked exception applies the default fix-up and computation continues.
// - Unmasked exception defers handling to the next wait or non-control instruction.
// - Mode bit set: pending unmasked exception raises vector 16 at that point.
// - Mode bit clear, ignore inactive: processor freezes until an external interrupt, ignore going active, or no unmasked exception pending.
// - Error output is registered: it goes active one cycle after an unmasked exception becomes pending.
// - Mode bit clear, ignore active: pending exception disregarded, execution continues.
// - Masked responses let one instruction raise several flags.
// - Flags stay set until clear, initialise, or state/environment overwrite.
// - Invalid sets stack fault flag 1 for stack faults, 0 for arithmetic.
// - Stack fault sets condition bit one on push overflow, clears on underflow.
// - Masked stack fault writes quiet NaN indefinite into destination.
// - Unmasked stack fault keeps stack top pointer and operands unchanged.
// - Unmasked invalid arithmetic keeps operands unaltered.
// - Pseudo-NaN, pseudoinfinity, unnormal and pseudodenormal encodings are unsupported.
// - Arithmetic on unsupported operand raises invalid; masked returns NaN indefinite.
// - Denormal operand sets its flag; masked proceeds, unmasked keeps operands.
//
// Our own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module fpu_numeric_exception_unit (
   // Clock and reset
   input  wire logic                           clk,
   input  wire logic                           rst_n,
   // AXI4-Lite slave
   input  wire logic [11:0]                    s_axi_awaddr,
   input  wire logic                           s_axi_awvalid,
   output logic                                s_axi_awready,
   input  wire logic [31:0]                    s_axi_wdata,
   input  wire logic [3:0]                     s_axi_wstrb,
   input  wire logic                           s_axi_wvalid,
   output logic                                s_axi_wready,
   output logic [1:0]                          s_axi_bresp,
   output logic                                s_axi_bvalid,
   input  wire logic                           s_axi_bready,
   input  wire logic [11:0]                    s_axi_araddr,
   input  wire logic                           s_axi_arvalid,
   output logic                                s_axi_arready,
   output logic [31:0]                         s_axi_rdata,
   output logic [1:0]                          s_axi_rresp,
   output logic                                s_axi_rvalid,
   input  wire logic                           s_axi_rready,
   // Instruction gate
   input  wire fpu_exc_pkg::insn_req_s         insn_req,
   output logic                                insn_go,
   output logic                                trap_req,
   output logic [7:0]                          trap_vector,
   output logic                                freeze,
   // Exception reports from the datapath
   input  wire fpu_exc_pkg::exc_report_s       exc_report,
   input  wire logic                           operand_chk,
   input  wire logic [fpu_exc_pkg::FP_W-1:0]   operand,
   input  wire logic                           top_upd,
   input  wire logic [fpu_exc_pkg::TOP_W-1:0]  top_new,
   output fpu_exc_pkg::exc_resp_s              exc_resp,
   // System pins
   input  wire logic                           ignore_numeric_error_input,
   input  wire logic                           ext_interrupt,
   output logic                                numeric_error_output
);
   // ***************************************
   // Functions
   // ***************************************
   function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic reg_hit(input logic [11:0] a);
      return (a == fpu_exc_pkg::OFS_STATUS) || (a == fpu_exc_pkg::OFS_CONTROL) ||
             (a == fpu_exc_pkg::OFS_COMMAND) || (a == fpu_exc_pkg::OFS_SYSCTL);
   endfunction

   // ***************************************
   // State
   // ***************************************
   logic [fpu_exc_pkg::NCLS-1:0]  flags_r;
   logic [fpu_exc_pkg::NCLS-1:0]  mask_r;
   logic                          sf_r;
   logic                          c1_r;
   logic [fpu_exc_pkg::TOP_W-1:0] top_r;
   logic                          mode_r;
   fpu_exc_pkg::gate_state_e      state_r;
   logic [11:0]                   awaddr_r;
   logic [31:0]                   wdata_r;
   logic [3:0]                    wstrb_r;
   logic [31:0]                   status_word;
   logic [31:0]                   wr_val;
   logic [31:0]                   ctl_val;
   logic                          pending;
   logic                          commit;
   logic                          wr_status;
   logic                          wr_control;
   logic                          do_clex;
   logic                          do_init;
   logic                          unsup;
   logic                          denorm_op;
   logic [fpu_exc_pkg::NCLS-1:0]  raised;
   logic                          inv_stack;
   logic                          gate_free;

   fpu_operand_classifier u_classify (
      .operand     (operand),
      .unsupported (unsup),
      .denormal    (denorm_op)
   );

   // ***************************************
   // Event decode
   // ***************************************
   always_comb begin
      raised = '0;
      inv_stack = exc_report.valid && exc_report.stack;
      raised[fpu_exc_pkg::IDX_INV]  = (exc_report.valid && (exc_report.inv_arith ||
                                       exc_report.stack)) || (operand_chk && unsup);
      raised[fpu_exc_pkg::IDX_ZERO] = exc_report.valid && exc_report.zero_div;
      raised[fpu_exc_pkg::IDX_DEN]  = (exc_report.valid && exc_report.denorm) ||
                                      (operand_chk && denorm_op);
      raised[fpu_exc_pkg::IDX_OVF]  = exc_report.valid && exc_report.overflow;
      raised[fpu_exc_pkg::IDX_UNF]  = exc_report.valid && exc_report.underflow;
      raised[fpu_exc_pkg::IDX_PREC] = exc_report.valid && exc_report.precision;
   end

   assign pending = |(flags_r & ~mask_r);
   assign commit  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign wr_val  = merge_strb(status_word, wdata_r, wstrb_r);
   assign ctl_val = merge_strb({26'h0, mask_r}, wdata_r, wstrb_r);
   assign wr_status  = commit && (awaddr_r == fpu_exc_pkg::OFS_STATUS);
   assign wr_control = commit && (awaddr_r == fpu_exc_pkg::OFS_CONTROL);
   assign do_clex = commit && (awaddr_r == fpu_exc_pkg::OFS_COMMAND) && wstrb_r[0] &&
                    wdata_r[fpu_exc_pkg::CMD_CLEX];
   assign do_init = commit && (awaddr_r == fpu_exc_pkg::OFS_COMMAND) && wstrb_r[0] &&
                    wdata_r[fpu_exc_pkg::CMD_INIT];

   always_comb begin
      status_word = '0;
      status_word[fpu_exc_pkg::SW_FLAG_LSB +: fpu_exc_pkg::NCLS] = flags_r;
      status_word[fpu_exc_pkg::SW_SF] = sf_r;
      status_word[fpu_exc_pkg::SW_ES] = pending;
      status_word[fpu_exc_pkg::SW_C1] = c1_r;
      status_word[fpu_exc_pkg::SW_TOP_LSB +: fpu_exc_pkg::TOP_W] = top_r;
   end

   // ***************************************
   // Exception flags
   // ***************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         flags_r <= fpu_exc_pkg::FLAG_RST;
      end else if (do_clex || do_init) begin
         flags_r <= raised;
      end else if (wr_status) begin
         flags_r <= wr_val[fpu_exc_pkg::SW_FLAG_LSB +: fpu_exc_pkg::NCLS] | raised;
      end else begin
         flags_r <= flags_r | raised;
      end
   end

   // ***************************************
   // Masks and mode
   // ***************************************
   always_ff @(posedge clk) begin
      if (!rst_n || do_init) begin
         mask_r <= fpu_exc_pkg::MASK_RST;
      end else if (wr_control) begin
         mask_r <= ctl_val[fpu_exc_pkg::NCLS-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mode_r <= 1'b0;
      end else if (commit && (awaddr_r == fpu_exc_pkg::OFS_SYSCTL) && wstrb_r[0]) begin
         mode_r <= wdata_r[fpu_exc_pkg::SYS_NE];
      end
   end

   // ***************************************
   // Stack fault, condition bit, top
   // ***************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sf_r <= 1'b0;
         c1_r <= 1'b0;
      end else if (raised[fpu_exc_pkg::IDX_INV]) begin
         sf_r <= inv_stack;
         if (inv_stack) begin
            c1_r <= exc_report.push;
         end
      end else if (do_init) begin
         sf_r <= 1'b0;
         c1_r <= 1'b0;
      end else if (wr_status) begin
         sf_r <= wr_val[fpu_exc_pkg::SW_SF];
         c1_r <= wr_val[fpu_exc_pkg::SW_C1];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n || do_init) begin
         top_r <= fpu_exc_pkg::TOP_RST;
      end else if (inv_stack && !mask_r[fpu_exc_pkg::IDX_INV]) begin
         top_r <= top_r;
      end else if (top_upd) begin
         top_r <= top_new;
      end else if (wr_status) begin
         top_r <= wr_val[fpu_exc_pkg::SW_TOP_LSB +: fpu_exc_pkg::TOP_W];
      end
   end

   // ***************************************
   // Response to the datapath
   // ***************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         exc_resp <= '0;
      end else begin
         exc_resp.fixup         <= |(raised & mask_r);
         exc_resp.qnan_write    <= raised[fpu_exc_pkg::IDX_INV] &&
                                   mask_r[fpu_exc_pkg::IDX_INV] &&
                                   (inv_stack || (operand_chk && unsup));
         exc_resp.keep_operands <= |(raised & ~mask_r);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         numeric_error_output <= 1'b0;
      end else begin
         numeric_error_output <= pending;
      end
   end

   // ***************************************
   // Instruction gate
   // ***************************************
   assign gate_free = insn_req.valid && !insn_go && !trap_req;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_r     <= fpu_exc_pkg::ST_RUN;
         insn_go     <= 1'b0;
         trap_req    <= 1'b0;
         trap_vector <= '0;
         freeze      <= 1'b0;
      end else begin
         insn_go  <= 1'b0;
         trap_req <= 1'b0;
         case (state_r)
            fpu_exc_pkg::ST_RUN: begin
               if (gate_free) begin
                  if (insn_req.kind == fpu_exc_pkg::K_CONTROL || !pending) begin
                     insn_go <= 1'b1;
                  end else if (mode_r) begin
                     trap_req    <= 1'b1;
                     trap_vector <= fpu_exc_pkg::VEC_NUMERIC;
                  end else if (ignore_numeric_error_input) begin
                     insn_go <= 1'b1;
                  end else begin
                     state_r <= fpu_exc_pkg::ST_FREEZE;
                     freeze  <= 1'b1;
                  end
               end
            end
            fpu_exc_pkg::ST_FREEZE: begin
               if (ext_interrupt || ignore_numeric_error_input || !pending) begin
                  state_r <= fpu_exc_pkg::ST_RUN;
                  freeze  <= 1'b0;
               end
            end
            default: begin
               state_r <= fpu_exc_pkg::ST_RUN;
               freeze  <= 1'b0;
            end
         endcase
      end
   end

   // ***************************************
   // AXI4-Lite write channel
   // ***************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= fpu_exc_pkg::RESP_OKAY;
         awaddr_r      <= '0;
         wdata_r       <= '0;
         wstrb_r       <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_r      <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_r      <= s_axi_wdata;
            wstrb_r      <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (commit) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= reg_hit(awaddr_r) ? fpu_exc_pkg::RESP_OKAY : fpu_exc_pkg::RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // ***************************************
   // AXI4-Lite read channel
   // ***************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= fpu_exc_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= reg_hit(s_axi_araddr) ? fpu_exc_pkg::RESP_OKAY : fpu_exc_pkg::RESP_SLVERR;
         case (s_axi_araddr)
            fpu_exc_pkg::OFS_STATUS:  s_axi_rdata <= status_word;
            fpu_exc_pkg::OFS_CONTROL: s_axi_rdata <= {26'h0, mask_r};
            fpu_exc_pkg::OFS_SYSCTL:  s_axi_rdata <= {31'h0, mode_r};
            default:                  s_axi_rdata <= '0;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ***************************************
   // Assertions
   // ***************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_blocked_insn;
      state_r == fpu_exc_pkg::ST_RUN && gate_free &&
      insn_req.kind != fpu_exc_pkg::K_CONTROL && pending;
   endsequence

   sequence s_freeze_entry;
      s_blocked_insn ##0 (!mode_r && !ignore_numeric_error_input);
   endsequence

   chk_error_pin: assert property (1'b1 |=> numeric_error_output == $past(pending))
      else $error("error output does not follow pending exception");
   chk_trap_vec16: assert property (s_blocked_insn ##0 mode_r |=> trap_req && !insn_go &&
                                    trap_vector == fpu_exc_pkg::VEC_NUMERIC)
      else $error("vector 16 trap not raised");
   chk_freeze_hold: assert property (s_freeze_entry |=> freeze && !insn_go)
      else $error("freeze not entered");
   chk_freeze_stay: assert property (state_r == fpu_exc_pkg::ST_FREEZE && pending &&
                                     !ext_interrupt && !ignore_numeric_error_input
                                     |=> freeze && !insn_go)
      else $error("freeze left without interrupt");
   chk_ignore_runs: assert property (s_blocked_insn ##0 (!mode_r && ignore_numeric_error_input)
                                     |=> insn_go && !freeze)
      else $error("ignored error still stalled");
   chk_control_passes: assert property (state_r == fpu_exc_pkg::ST_RUN && gate_free &&
                                        insn_req.kind == fpu_exc_pkg::K_CONTROL |=> insn_go)
      else $error("control instruction blocked");
   chk_flags_sticky: assert property (!do_clex && !do_init && !wr_status
                                      |=> &(flags_r | ~$past(flags_r)))
      else $error("flag dropped without clear");
   chk_stack_cond: assert property (inv_stack |=> sf_r && c1_r == $past(exc_report.push))
      else $error("stack fault flags wrong");
   chk_arith_sf: assert property (raised[fpu_exc_pkg::IDX_INV] && !inv_stack |=> !sf_r)
      else $error("arithmetic invalid set stack flag");
   chk_qnan_stack: assert property (inv_stack && mask_r[fpu_exc_pkg::IDX_INV]
                                    |=> exc_resp.qnan_write && exc_resp.fixup)
      else $error("masked stack fault without NaN write");
   chk_top_hold: assert property (inv_stack && !mask_r[fpu_exc_pkg::IDX_INV] && !do_init
                                  |=> top_r == $past(top_r) && exc_resp.keep_operands)
      else $error("top moved on unmasked stack fault");
   chk_unsup_inv: assert property (operand_chk && unsup |=> flags_r[fpu_exc_pkg::IDX_INV])
      else $error("unsupported operand not flagged");
endmodule
`default_nettype wire

// File: ext_irq_model.sv
`timescale 1ns/1ps
`default_nettype none
module ext_irq_model #(
   parameter int DLY = 3
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Pins
   input  wire logic numeric_error_output,
   output logic      ext_interrupt
);
   // ***************
   // Delayed answer
   // ***************
   logic [DLY-1:0] dly_r;
   always_ff @(posedge clk) begin
      if (!rst_n) dly_r <= '0;
      else dly_r <= {dly_r[DLY-2:0], numeric_error_output};
   end
   assign ext_interrupt = dly_r[DLY-1] & numeric_error_output;
endmodule
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   // ***************
   // Signals
   // ***************
   logic        clk = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0, operand_chk = 0, top_upd = 0;
   logic        ignore_numeric_error_input = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid, insn_go, trap_req, freeze, ext_interrupt;
   logic        numeric_error_output;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, st;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic [7:0]  trap_vector;
   logic [2:0]  top_new = 0, res, resp;
   logic [79:0] operand = 0;
   int          n_fail = 0, num_checks = 0, cycles = 0;
   fpu_exc_pkg::insn_req_s   insn_req = '0;
   fpu_exc_pkg::exc_report_s exc_report = '0;
   fpu_exc_pkg::exc_resp_s   exc_resp;
   fpu_numeric_exception_unit fpu_numeric_exception_unit_i (.clk, .rst_n, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .insn_req, .insn_go, .trap_req,
      .trap_vector, .freeze, .exc_report, .operand_chk, .operand, .top_upd, .top_new, .exc_resp,
      .ignore_numeric_error_input, .ext_interrupt, .numeric_error_output);
   ext_irq_model ext_irq_model_i (.clk, .rst_n, .numeric_error_output, .ext_interrupt);
   initial begin
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_fail++;
         final_report();
      end
   end
   // ***************
   // Tasks
   // ***************
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      st = s_axi_rdata;
      rsp = s_axi_rresp;
   endtask
   task automatic ins(input fpu_exc_pkg::insn_kind_e k);
      @(posedge clk);
      insn_req <= '{valid: 1'b1, kind: k};
      do begin
         @(posedge clk);
         res = {insn_go, trap_req, freeze};
      end while (res == 3'b000);
      insn_req <= '0;
   endtask
   task automatic rep(input logic [8:0] r, input logic c, input logic [79:0] op, input logic tu);
      @(posedge clk);
      exc_report <= r;
      operand_chk <= c;
      operand <= op;
      top_upd <= tu;
      top_new <= 3'h5;
      @(posedge clk);
      exc_report <= '0;
      operand_chk <= 1'b0;
      top_upd <= 1'b0;
      @(posedge clk);
      resp = exc_resp;
   endtask
   // ***************
   // Tests
   // ***************
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      rd(fpu_exc_pkg::OFS_CONTROL);
      chk("control", st, 32'h3f);
      rd(12'h010);
      chk("rresp", rsp, 2'h2);
      $display("test reset done");
      rep(9'h102, 1'b1, 80'h1, 1'b0);
      chk("fixup", resp[2], 1'b1);
      ins(fpu_exc_pkg::K_ARITH);
      chk("gate", res, 3'b100);
      rep(9'h160, 1'b0, '0, 1'b0);
      chk("resp", resp, 3'b110);
      rd(fpu_exc_pkg::OFS_STATUS);
      chk("status", st, 32'h255);
      chk("err", numeric_error_output, 1'b0);
      wr(fpu_exc_pkg::OFS_COMMAND, 32'h1);
      rd(fpu_exc_pkg::OFS_STATUS);
      chk("status", st, 32'h240);
      $display("test masked done");
      wr(fpu_exc_pkg::OFS_CONTROL, 32'h3e);
      rep(9'h000, 1'b1, 80'h7fff_4000_0000_0000_0000, 1'b0);
      chk("keep", resp[0], 1'b1);
      rd(fpu_exc_pkg::OFS_STATUS);
      chk("status", st, 32'h281);
      chk("err", numeric_error_output, 1'b1);
      wr(fpu_exc_pkg::OFS_SYSCTL, 32'h1);
      ins(fpu_exc_pkg::K_ARITH);
      chk("gate", res, 3'b010);
      chk("vector", trap_vector, 8'h10);
      ins(fpu_exc_pkg::K_CONTROL);
      chk("gate", res, 3'b100);
      ins(fpu_exc_pkg::K_WAIT);
      chk("gate", res, 3'b010);
      $display("test trap done");
      wr(fpu_exc_pkg::OFS_SYSCTL, 32'h0);
      ignore_numeric_error_input <= 1'b1;
      ins(fpu_exc_pkg::K_ARITH);
      chk("gate", res, 3'b100);
      ignore_numeric_error_input <= 1'b0;
      wr(fpu_exc_pkg::OFS_COMMAND, 32'h1);
      rep(9'h140, 1'b0, '0, 1'b1);
      chk("resp", resp, 3'b001);
      ins(fpu_exc_pkg::K_ARITH);
      chk("gate", res, 3'b001);
      for (int i = 0; i < 20 && freeze; i++) @(posedge clk);
      chk("freeze", freeze, 1'b0);
      rd(fpu_exc_pkg::OFS_STATUS);
      chk("status", st, 32'hc1);
      wr(fpu_exc_pkg::OFS_COMMAND, 32'h2);
      rd(fpu_exc_pkg::OFS_STATUS);
      chk("status", st, 32'h0);
      chk("err", numeric_error_output, 1'b0);
      $display("test freeze done");
      final_report();
   end
endmodule
`default_nettype wire
